/* logic/tbsc_pkg.sv */
package tbsc_pkg;
    // Anticollision states, Gray coded along the usual path
    typedef enum logic [2:0] {
        ST_POWER_OFF = 3'h0,
        ST_IDLE = 3'h1,
        ST_WAITING = 3'h3,
        ST_READY = 3'h2,
        ST_ACTIVE = 3'h6,
        ST_HALT = 3'h7
    } tbsc_state_t;

    // Decoded command codes from the frame decoder
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_REQ_WUP = 3'h1,
        CMD_SLOT_MARKER = 3'h2,
        CMD_ATTRIB = 3'h3,
        CMD_HLTB = 3'h4,
        CMD_DESELECT = 3'h5,
        CMD_BLOCK = 3'h6,
        CMD_OTHER = 3'h7
    } tbsc_cmd_t;

    // Response kinds requested from the framer
    typedef enum logic [1:0] {
        RSP_NONE = 2'h0,
        RSP_ATQB = 2'h1,
        RSP_HALT_ACK = 2'h2,
        RSP_ATTRIB_ACK = 2'h3
    } tbsc_rsp_t;

    // One decoded request
    typedef struct packed {
        tbsc_cmd_t cmd;
        logic [7:0] family_code;
        logic [7:0] param;
        logic [7:0] slot_byte;
        logic [3:0] card_number;
        logic id_match;
    } tbsc_req_t;

    // Request parameter byte fields
    localparam int PARAM_WUPB_BIT = 3;
    localparam int PARAM_N_LSB = 0;
    localparam int PARAM_N_W = 3;
    localparam logic [2:0] N_CODE_MAX = 3'h4;
    // Slot marker byte layout
    localparam logic [3:0] SLOT_MARKER_LOW = 4'h5;
    localparam int SLOT_NUM_LSB = 4;
    // Family code matching
    localparam logic [7:0] FAMILY_ANY = 8'h00;
    localparam logic [3:0] FAMILY_LOW_WILD = 4'h0;
    // Reset values and LFSR taps
    localparam logic [3:0] CARD_NUMBER_RST = 4'h0;
    localparam logic [3:0] SLOT_PICK_RST = 4'h0;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
endpackage

/* logic/tbsc_slot_draw.sv */
`timescale 1ns/100ps
`default_nettype none
// Free-running LFSR; a draw is masked to 0..N-1 plus one, giving uniform 1..N with slot 16 held as 0 in four bits
module tbsc_slot_draw
    import tbsc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [2:0] n_code_in,
    output logic [3:0] pick_out
);
    logic [15:0] lfsr_r;
    logic [15:0] lfsr_nxt;
    logic [3:0] mask;

    // Galois step every enabled cycle so the draw depends on command timing
    always_comb
    begin
        lfsr_nxt = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? LFSR_TAPS : 16'h0000);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            lfsr_r <= LFSR_SEED;
        else if (ce_in)
            lfsr_r <= lfsr_nxt;
    end

    // Power of two slot counts make masking exact, no modulo bias
    always_comb
    begin
        unique case (n_code_in)
            3'h0: mask = 4'h0;
            3'h1: mask = 4'h1;
            3'h2: mask = 4'h3;
            3'h3: mask = 4'h7;
            default: mask = 4'hf;
        endcase
        pick_out = (lfsr_r[3:0] & mask) + 4'h1;
    end
endmodule // tbsc_slot_draw
`default_nettype wire

/* logic/tbsc_state_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module tbsc_state_ctrl
    import tbsc_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic FIELD_PRESENT_IN,
    input wire logic REQ_VALID_IN,
    input wire tbsc_req_t REQ_IN,
    input wire logic [7:0] OWN_FAMILY_CODE_IN,
    input wire logic [31:0] OWN_PSEUDO_UNIQUE_ID_IN,
    input wire logic [3:0] OWN_MAX_BUFFER_LENGTH_INDEX_IN,
    input wire logic [7:0] PROTO_INFO_BYTE1_LOW_IN,
    output tbsc_state_t STATE_OUT,
    output logic RSP_VALID_OUT,
    output tbsc_rsp_t RSP_KIND_OUT,
    output logic [31:0] RSP_PSEUDO_UNIQUE_ID_OUT,
    output logic [7:0] RSP_PROTO_INFO_BYTE1_OUT,
    output logic BLOCK_ACCEPT_OUT,
    output logic [3:0] CARD_NUMBER_OUT,
    output logic [3:0] SLOT_PICK_OUT
);
    tbsc_state_t state_r;
    tbsc_state_t state_nxt;
    logic [3:0] card_number_r;
    logic [3:0] slot_pick_r;
    logic rsp_valid_r;
    tbsc_rsp_t rsp_kind_r;
    tbsc_rsp_t rsp_nxt;
    logic [31:0] rsp_id_r;
    logic [7:0] rsp_info_r;
    logic block_accept_r;
    logic [3:0] fresh_pick;
    logic [2:0] n_code;
    logic is_wupb;
    logic family_ok;
    logic n_ok;
    logic req_hit;
    logic wup_hit;
    logic slot_hit;
    logic bypass;
    logic take_pick;
    logic take_card;
    logic attrib_hit;
    logic halt_hit;
    logic deselect_hit;
    logic family_any;
    logic family_nibble;
    tbsc_state_t req_target;

    // Request parameter decode
    assign n_code = REQ_IN.param[PARAM_N_LSB +: PARAM_N_W];
    assign is_wupb = REQ_IN.param[PARAM_WUPB_BIT];
    // Reserved slot codes are treated as not a valid request
    assign n_ok = (n_code <= N_CODE_MAX);

    // Wildcard forms of the requested family code
    assign family_any = (REQ_IN.family_code == FAMILY_ANY);
    assign family_nibble = (REQ_IN.family_code[3:0] == FAMILY_LOW_WILD);

    // Family code matching with the two wildcard forms
    always_comb
    begin
        if (family_any)
            family_ok = 1'b1;
        else if (family_nibble)
            family_ok = (REQ_IN.family_code[7:4] == OWN_FAMILY_CODE_IN[7:4]);
        else
            family_ok = (REQ_IN.family_code == OWN_FAMILY_CODE_IN);
    end

    // Random pick for this request
    tbsc_slot_draw u_draw (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .ce_in(CE_IN),
        .n_code_in(n_code),
        .pick_out(fresh_pick)
    );

    // Command qualifiers
    assign req_hit = REQ_VALID_IN && (REQ_IN.cmd == CMD_REQ_WUP) && n_ok;
    assign wup_hit = req_hit && is_wupb;
    // Slot code nnnn maps to slot nnnn+1, so compare against pick-1
    assign slot_hit = REQ_VALID_IN && (REQ_IN.cmd == CMD_SLOT_MARKER)
        && (REQ_IN.slot_byte[3:0] == SLOT_MARKER_LOW)
        && (REQ_IN.slot_byte[SLOT_NUM_LSB +: 4] != 4'h0)
        && (REQ_IN.slot_byte[SLOT_NUM_LSB +: 4] == slot_pick_r - 4'h1);
    assign bypass = (n_code == 3'h0) || (fresh_pick == 4'h1);

    // Identifier compare is left to the frame decoder, seen here as one flag
    assign attrib_hit = REQ_VALID_IN && REQ_IN.id_match
        && (REQ_IN.cmd == CMD_ATTRIB);
    assign halt_hit = REQ_VALID_IN && REQ_IN.id_match
        && (REQ_IN.cmd == CMD_HLTB);
    // Card number compare uses the stored value, zero until an ATTRIB lands
    assign deselect_hit = REQ_VALID_IN && (REQ_IN.cmd == CMD_DESELECT)
        && (REQ_IN.card_number == card_number_r);

    // Outcome of an accepted REQB or WUPB
    always_comb
    begin
        if (!family_ok)
            req_target = ST_IDLE;
        else if (bypass)
            req_target = ST_READY;
        else
            req_target = ST_WAITING;
    end

    // Next state and response selection
    always_comb
    begin
        state_nxt = state_r;
        rsp_nxt = RSP_NONE;
        take_pick = 1'b0;
        take_card = 1'b0;
        if (!FIELD_PRESENT_IN)
        begin
            state_nxt = ST_POWER_OFF;
        end
        else
        begin
            unique case (state_r)
                ST_POWER_OFF:
                begin
                    state_nxt = ST_IDLE;
                end
                ST_IDLE:
                begin
                    // Mismatch in idle leaves things as they were
                    if (req_hit && family_ok)
                    begin
                        state_nxt = req_target;
                        take_pick = 1'b1;
                    end
                end
                ST_WAITING:
                begin
                    // Only requests and slot markers are heard here
                    if (req_hit)
                    begin
                        state_nxt = req_target;
                        take_pick = 1'b1;
                    end
                    else if (slot_hit)
                    begin
                        // Pick is kept, the reader may ask again later
                        state_nxt = ST_READY;
                    end
                end
                ST_READY:
                begin
                    // A repeated request re-runs the draw and may leave ready
                    if (req_hit)
                    begin
                        state_nxt = req_target;
                        take_pick = 1'b1;
                    end
                    else if (attrib_hit)
                    begin
                        state_nxt = ST_ACTIVE;
                        take_card = 1'b1;
                        rsp_nxt = RSP_ATTRIB_ACK;
                    end
                    else if (halt_hit)
                    begin
                        state_nxt = ST_HALT;
                        rsp_nxt = RSP_HALT_ACK;
                    end
                end
                ST_HALT:
                begin
                    // A parked tag must be woken, a plain request is dropped
                    if (wup_hit)
                    begin
                        state_nxt = req_target;
                        take_pick = 1'b1;
                    end
                end
                ST_ACTIVE:
                begin
                    // Block frames pass through untouched, only deselect counts
                    if (deselect_hit)
                    begin
                        state_nxt = ST_HALT;
                        rsp_nxt = RSP_HALT_ACK;
                    end
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                end
            endcase
            // Any arrival in ready announces itself, whatever the path
            if (state_nxt == ST_READY && state_r != ST_READY)
                rsp_nxt = RSP_ATQB;
            else if (state_nxt == ST_READY && take_pick)
                rsp_nxt = RSP_ATQB;
        end
    end

    // Anticollision state
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            state_r <= ST_POWER_OFF;
        else if (CE_IN)
            state_r <= state_nxt;
    end

    // Slot pick, lost with the field
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            slot_pick_r <= SLOT_PICK_RST;
        else if (CE_IN)
        begin
            if (!FIELD_PRESENT_IN)
                slot_pick_r <= SLOT_PICK_RST;
            else if (take_pick)
                slot_pick_r <= fresh_pick;
        end
    end

    // Card number assigned by ATTRIB
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            card_number_r <= CARD_NUMBER_RST;
        else if (CE_IN)
        begin
            if (!FIELD_PRESENT_IN)
                card_number_r <= CARD_NUMBER_RST;
            else if (take_card)
                card_number_r <= REQ_IN.card_number;
        end
    end

    // Response request, a one cycle pulse for the framer
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            rsp_valid_r <= 1'b0;
        else if (CE_IN)
            rsp_valid_r <= (rsp_nxt != RSP_NONE);
    end

    // Response kind, valid with the pulse only; it returns to RSP_NONE on the next enabled cycle
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            rsp_kind_r <= RSP_NONE;
        else if (CE_IN)
            rsp_kind_r <= rsp_nxt;
    end

    // ATQB payload, loaded only with an ATQB so it stays stable otherwise
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
        begin
            rsp_id_r <= 32'h0000_0000;
            rsp_info_r <= 8'h00;
        end
        else if (CE_IN)
        begin
            if (rsp_nxt == RSP_ATQB)
            begin
                rsp_id_r <= OWN_PSEUDO_UNIQUE_ID_IN;
                rsp_info_r <= {PROTO_INFO_BYTE1_LOW_IN[7:4],
                    OWN_MAX_BUFFER_LENGTH_INDEX_IN};
            end
        end
    end

    // Block protocol gate, sampled with the state it belongs to
    always_ff @(posedge REF_CLK_IN)
    begin
        if (RST_IN)
            block_accept_r <= 1'b0;
        else if (CE_IN)
            block_accept_r <= (state_nxt == ST_ACTIVE);
    end

    assign STATE_OUT = state_r;
    assign RSP_VALID_OUT = rsp_valid_r;
    assign RSP_KIND_OUT = rsp_kind_r;
    assign RSP_PSEUDO_UNIQUE_ID_OUT = rsp_id_r;
    assign RSP_PROTO_INFO_BYTE1_OUT = rsp_info_r;
    assign BLOCK_ACCEPT_OUT = block_accept_r;
    assign CARD_NUMBER_OUT = card_number_r;
    assign SLOT_PICK_OUT = slot_pick_r;
endmodule // tbsc_state_ctrl
`default_nettype wire

/* tb/tbsc_reader_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tbsc_reader_model
    import tbsc_pkg::*;
(
    input wire logic clk_in,
    output logic req_valid_out,
    output tbsc_req_t req_out
);
    initial
    begin
        req_valid_out = 1'b0;
        req_out = '0;
    end
    // One decoded frame, one cycle; a gap edge first so drives never collide
    task automatic send(input tbsc_cmd_t c, input logic [7:0] f, input logic [7:0] p,
                        input logic [3:0] a, input logic m);
        @(posedge clk_in);
        #1;
        req_out = '{c, f, p, {a, SLOT_MARKER_LOW}, a, m};
        req_valid_out = 1'b1;
        @(posedge clk_in);
        #1;
        req_valid_out = 1'b0;
        req_out = tbsc_req_t'(~req_out); // Stale fields must not look valid
    endtask
endmodule // tbsc_reader_model
`default_nettype wire

/* tb/tbsc_state_ctrl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tbsc_state_ctrl_monitor
    import tbsc_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic CE_IN,
    input wire logic FIELD_PRESENT_IN,
    input wire logic REQ_VALID_IN,
    input wire tbsc_req_t REQ_IN,
    input wire tbsc_state_t STATE_OUT,
    input wire logic RSP_VALID_OUT,
    input wire tbsc_rsp_t RSP_KIND_OUT,
    input wire logic [3:0] CARD_NUMBER_OUT,
    input wire logic [3:0] SLOT_PICK_OUT
);
    default clocking mclk @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    // Request taken this edge; CE low freezes everything
    logic tk;
    assign tk = CE_IN && FIELD_PRESENT_IN && REQ_VALID_IN;
    field_loss_a: assert property (CE_IN && !FIELD_PRESENT_IN |=>
        STATE_OUT == ST_POWER_OFF && CARD_NUMBER_OUT == 4'h0) else $error("field loss kept state");
    field_entry_a: assert property (CE_IN && FIELD_PRESENT_IN && STATE_OUT == ST_POWER_OFF |=>
        STATE_OUT == ST_IDLE && !RSP_VALID_OUT) else $error("no silent entry to idle");
    ready_entry_a: assert property (STATE_OUT == ST_READY && $past(STATE_OUT) != ST_READY |->
        RSP_VALID_OUT && RSP_KIND_OUT == RSP_ATQB) else $error("ready without answer");
    halt_entry_a: assert property (STATE_OUT == ST_HALT && $past(STATE_OUT) != ST_HALT |->
        RSP_VALID_OUT && RSP_KIND_OUT == RSP_HALT_ACK) else $error("halt without answer");
    active_entry_a: assert property (STATE_OUT == ST_ACTIVE && $past(STATE_OUT) != ST_ACTIVE |->
        $past(STATE_OUT) == ST_READY && RSP_VALID_OUT && RSP_KIND_OUT == RSP_ATTRIB_ACK)
        else $error("bad entry to active");
    idle_filter_a: assert property (tk && STATE_OUT == ST_IDLE && REQ_IN.cmd != CMD_REQ_WUP |=>
        STATE_OUT == ST_IDLE && !RSP_VALID_OUT) else $error("idle reacted");
    halt_filter_a: assert property (tk && STATE_OUT == ST_HALT &&
        !(REQ_IN.cmd == CMD_REQ_WUP && REQ_IN.param[PARAM_WUPB_BIT]) |=>
        STATE_OUT == ST_HALT && !RSP_VALID_OUT) else $error("halt reacted");
    quiet_hold_a: assert property (CE_IN && FIELD_PRESENT_IN && !REQ_VALID_IN &&
        STATE_OUT != ST_POWER_OFF |=> !RSP_VALID_OUT && $stable(STATE_OUT) &&
        $stable(CARD_NUMBER_OUT) && $stable(SLOT_PICK_OUT)) else $error("change without request");
    attrib_store_a: assert property (tk && STATE_OUT == ST_READY && REQ_IN.cmd == CMD_ATTRIB &&
        REQ_IN.id_match |=> STATE_OUT == ST_ACTIVE && CARD_NUMBER_OUT == $past(REQ_IN.card_number))
        else $error("attrib not taken");
    deselect_halt_a: assert property (tk && STATE_OUT == ST_ACTIVE &&
        REQ_IN.cmd == CMD_DESELECT && REQ_IN.card_number == CARD_NUMBER_OUT |=>
        STATE_OUT == ST_HALT) else $error("deselect not taken");
endmodule // tbsc_state_ctrl_monitor
bind tbsc_state_ctrl tbsc_state_ctrl_monitor u_tbsc_state_ctrl_monitor (.REF_CLK_IN(REF_CLK_IN),
    .RST_IN(RST_IN), .CE_IN(CE_IN), .FIELD_PRESENT_IN(FIELD_PRESENT_IN),
    .REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN), .STATE_OUT(STATE_OUT),
    .RSP_VALID_OUT(RSP_VALID_OUT), .RSP_KIND_OUT(RSP_KIND_OUT),
    .CARD_NUMBER_OUT(CARD_NUMBER_OUT), .SLOT_PICK_OUT(SLOT_PICK_OUT));
`default_nettype wire

/* tb/typeb_slave_state_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module typeb_slave_state_control_tb_top;
    import tbsc_pkg::*;
    localparam logic [7:0] FAM = 8'h3a;
    localparam logic [31:0] OWN_ID = 32'h5a17c0de;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic field = 1'b1;
    logic ce = 1'b1;
    logic req_valid, rsp_valid, blk;
    tbsc_req_t req;
    tbsc_state_t state;
    tbsc_rsp_t kind;
    logic [31:0] rsp_id;
    logic [7:0] info;
    logic [3:0] card, pick;
    int failures = 0;
    int cmp_count = 0;
    // 125 MHz
    always #4 clk = ~clk;
    tbsc_state_ctrl u_tbsc_state_ctrl (.REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
        .FIELD_PRESENT_IN(field), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .OWN_FAMILY_CODE_IN(FAM), .OWN_PSEUDO_UNIQUE_ID_IN(OWN_ID),
        .OWN_MAX_BUFFER_LENGTH_INDEX_IN(4'h8), .PROTO_INFO_BYTE1_LOW_IN(8'hc7),
        .STATE_OUT(state), .RSP_VALID_OUT(rsp_valid), .RSP_KIND_OUT(kind),
        .RSP_PSEUDO_UNIQUE_ID_OUT(rsp_id), .RSP_PROTO_INFO_BYTE1_OUT(info),
        .BLOCK_ACCEPT_OUT(blk), .CARD_NUMBER_OUT(card), .SLOT_PICK_OUT(pick));
    tbsc_reader_model u_tbsc_reader_model (.clk_in(clk), .req_valid_out(req_valid),
        .req_out(req));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // State after a taken request, and the answer if one is due
    task automatic expect_out(input tbsc_state_t st, input tbsc_rsp_t k);
        check("state", state, st);
        check("rsp_valid", rsp_valid, k != RSP_NONE);
        if (k != RSP_NONE)
            check("rsp_kind", kind, k);
    endtask
    task automatic tx(input tbsc_cmd_t c, input logic [7:0] f, input logic [7:0] p,
                      input logic [3:0] a, input logic m);
        u_tbsc_reader_model.send(c, f, p, a, m);
    endtask
    task automatic t_powerup();
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        @(posedge clk);
        #1;
        expect_out(ST_IDLE, RSP_NONE);
        $display("test powerup done");
    endtask
    // Idle filtering, then wildcard, nibble and exact family codes
    task automatic t_family();
        logic [7:0] fams [3] = '{8'h00, 8'h30, FAM};
        tx(CMD_REQ_WUP, 8'h40, 8'h00, 4'h0, 1'b0);
        expect_out(ST_IDLE, RSP_NONE);
        for (int c = 2; c < 8; c++)
        begin
            tx(tbsc_cmd_t'(c[2:0]), FAM, 8'h08, 4'h1, 1'b1);
            expect_out(ST_IDLE, RSP_NONE);
        end
        foreach (fams[i])
        begin
            tx(CMD_REQ_WUP, fams[i], 8'h00, 4'h0, 1'b0);
            expect_out(ST_READY, RSP_ATQB);
            check("atqb_id", rsp_id, OWN_ID);
            check("info", info, 8'hc8);
            tx(CMD_REQ_WUP, 8'h31, 8'h00, 4'h0, 1'b0);
            expect_out(ST_IDLE, RSP_NONE);
        end
        $display("test family done");
    endtask
    // Slot counts 2..16; the draw is random so the path follows the pick
    task automatic t_slots();
        logic [3:0] d;
        tx(CMD_REQ_WUP, FAM, 8'h05, 4'h0, 1'b0);
        expect_out(ST_IDLE, RSP_NONE);
        for (int n = 1; n <= 4; n++)
        begin
            tx(CMD_REQ_WUP, FAM, 8'(n), 4'h0, 1'b0);
            d = pick - 4'h1;
            check("pick", {1'b0, d} < (5'h1 << n), 1'b1);
            if (d == 4'h0)
                expect_out(ST_READY, RSP_ATQB);
            else
            begin
                expect_out(ST_WAITING, RSP_NONE);
                tx(CMD_HLTB, FAM, 8'h00, 4'h0, 1'b1);
                expect_out(ST_WAITING, RSP_NONE);
                tx(CMD_SLOT_MARKER, 8'h00, 8'h00, d ^ 4'h1, 1'b0);
                expect_out(ST_WAITING, RSP_NONE);
                tx(CMD_SLOT_MARKER, 8'h00, 8'h00, d, 1'b0);
                expect_out(ST_READY, RSP_ATQB);
            end
            tx(CMD_REQ_WUP, 8'h31, 8'h00, 4'h0, 1'b0);
            expect_out(ST_IDLE, RSP_NONE);
        end
        $display("test slots done");
    endtask
    task automatic t_select();
        tx(CMD_REQ_WUP, FAM, 8'h00, 4'h0, 1'b0);
        tx(CMD_DESELECT, 8'h00, 8'h00, 4'h0, 1'b0);
        expect_out(ST_READY, RSP_NONE);
        tx(CMD_ATTRIB, 8'h00, 8'h00, 4'h9, 1'b1);
        expect_out(ST_ACTIVE, RSP_ATTRIB_ACK);
        check("card", card, 4'h9);
        check("block", blk, 1'b1);
        tx(CMD_DESELECT, 8'h00, 8'h00, 4'h8, 1'b0);
        expect_out(ST_ACTIVE, RSP_NONE);
        tx(CMD_DESELECT, 8'h00, 8'h00, 4'h9, 1'b0);
        expect_out(ST_HALT, RSP_HALT_ACK);
        check("block", blk, 1'b0);
        tx(CMD_REQ_WUP, FAM, 8'h00, 4'h0, 1'b0);
        expect_out(ST_HALT, RSP_NONE);
        tx(CMD_REQ_WUP, FAM, 8'h08, 4'h0, 1'b0);
        expect_out(ST_READY, RSP_ATQB);
        tx(CMD_HLTB, 8'h00, 8'h00, 4'h0, 1'b1);
        expect_out(ST_HALT, RSP_HALT_ACK);
        tx(CMD_REQ_WUP, 8'h31, 8'h08, 4'h0, 1'b0);
        expect_out(ST_IDLE, RSP_NONE);
        $display("test select done");
    endtask
    // Clock enable low must freeze everything, requests included
    task automatic t_hold();
        ce = 1'b0;
        tx(CMD_REQ_WUP, FAM, 8'h00, 4'h0, 1'b0);
        expect_out(ST_IDLE, RSP_NONE);
        ce = 1'b1;
        tx(CMD_REQ_WUP, FAM, 8'h00, 4'h0, 1'b0);
        expect_out(ST_READY, RSP_ATQB);
        $display("test hold done");
    endtask
    task automatic t_field();
        tx(CMD_REQ_WUP, FAM, 8'h00, 4'h0, 1'b0);
        tx(CMD_ATTRIB, 8'h00, 8'h00, 4'h6, 1'b1);
        field = 1'b0;
        @(posedge clk);
        #1;
        expect_out(ST_POWER_OFF, RSP_NONE);
        check("card", card, 4'h0);
        field = 1'b1;
        @(posedge clk);
        #1;
        expect_out(ST_IDLE, RSP_NONE);
        $display("test field done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        t_powerup();
        t_family();
        t_slots();
        t_select();
        t_hold();
        t_field();
        finish_test();
    end
    // Cuts a hung sequence short
    initial
    begin
        #100000;
        failures++;
        finish_test();
    end
endmodule // typeb_slave_state_control_tb_top
`default_nettype wire
